// ---- shared/psf_pkg.sv ----
package psf_pkg;

   // Register map, byte addresses on the 8-bit register port.
   localparam logic [7:0] CFG_OFFSET        = 8'h00;
   localparam logic [7:0] STATE_OFFSET      = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
   localparam logic [7:0] IRQ_CLEAR_OFFSET  = 8'h0c;
   localparam logic [7:0] IRQ_ENABLE_OFFSET = 8'h10;

   // Configuration register fields.
   localparam int CFG_INVERT_BIT = 0;
   localparam int CFG_LPOFF_BIT  = 1;
   localparam int CFG_EDGE_BIT   = 2;
   localparam int CFG_LIMIT_LSB  = 4;
   localparam int LIMIT_W        = 4;

   // State register fields.
   localparam int STATE_CODE_LSB = 0;
   localparam int STATE_COUNT_LSB = 4;

   // Interrupt event bits.
   localparam int EV_RUN     = 0;
   localparam int EV_STANDBY = 1;
   localparam int EV_WDRST   = 2;
   localparam int EV_FAULT   = 3;
   localparam int EV_PWRUP   = 4;
   localparam int EV_W       = 5;

   // Reset values.
   localparam logic                 CFG_INVERT_RST = 1'b0;
   localparam logic                 CFG_LPOFF_RST  = 1'b0;
   localparam logic                 CFG_EDGE_RST   = 1'b0;
   localparam logic [LIMIT_W-1:0]   CFG_LIMIT_RST  = 4'h3;
   localparam logic [EV_W-1:0]      IRQ_ENABLE_RST = 5'h00;

   // Watchdog reset dwell time.
   localparam int CLK_PERIOD_NS = 10;
   localparam int WD_DELAY_NS   = 30000;
   localparam int WD_DELAY_CYC  =
      (WD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WD_CNT_W      = 12;

   // Top-level power states, Gray coded along the power-up path.
   typedef enum logic [2:0] {
      ST_LOW_POWER_OFF_STATE  = 3'h0,
      ST_QUICK_POWERUP_OFF_STATE = 3'h1,
      ST_PWRUP   = 3'h3,
      ST_RUN     = 3'h2,
      ST_STANDBY = 3'h6,
      ST_WD_RST  = 3'h7,
      ST_FAULT   = 3'h5
   } psf_state_t;

endpackage : psf_pkg

// ---- verilog/psf_power_state_fsm.sv ----
`timescale 1ns/10ps

// Behaviour
// - In standby, go to run when sleep request equals the invert bit.
// - In run, go to standby when sleep request differs from invert.
// - From run or standby, a hard watchdog reset enters watchdog reset.
// - Return from watchdog reset to run after 30 us if count < limit.
// - A count at the limit ends watchdog reset in a fault power-down.
// - Low power off enabled, board test low: pass to quick power-up off.
// - In level mode a high power-on request is a power-up event.
// - In edge mode a falling power-on request is a power-up event.
// - A power-up event needs good supply, no overheat and no load faults.
// - Board test enable high passes low power off to quick power-up off.
// - Quick power-up off advances on a clean self-check and an event.
module psf_power_state_fsm (
   // Clock and reset.
   input  wire logic        i_sys_clk,
   input  wire logic        i_arst_n,
   // Register port.
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wr_data,
   input  wire logic        i_wr_strobe,
   input  wire logic        i_rd_strobe,
   output logic      [31:0] o_rd_data,
   // System inputs.
   input  wire logic        i_sleep_request,
   input  wire logic        i_power_on_request,
   input  wire logic        i_board_test_enable,
   input  wire logic        i_hard_wd_reset,
   input  wire logic        i_vin_above_uv,
   input  wire logic        i_vin_below_ovlo,
   input  wire logic        i_ovlo_disable,
   input  wire logic        i_below_thermal_sd,
   input  wire logic        i_trim_load_fault,
   input  wire logic        i_fuse_load_fault,
   input  wire logic        i_self_check_fault,
   input  wire logic        i_seq_done,
   // Status outputs.
   output logic      [2:0]  o_power_state,
   output logic             o_fault_powerdown,
   output logic             o_irq
);

   localparam int LW = psf_pkg::LIMIT_W;
   localparam int EW = psf_pkg::EV_W;
   localparam int CW = psf_pkg::WD_CNT_W;
   localparam logic [CW-1:0] WD_LAST =
      CW'(psf_pkg::WD_DELAY_CYC - 1);

   psf_pkg::psf_state_t state_ff;
   psf_pkg::psf_state_t nxt_state;

   logic          invert_ff;
   logic          lpoff_en_ff;
   logic          edge_sel_ff;
   logic [LW-1:0] limit_ff;
   logic [LW-1:0] wd_count_ff;
   logic [LW-1:0] nxt_wd_count;
   logic [CW-1:0] wd_delay_ff;
   logic [CW-1:0] nxt_wd_delay;
   logic          pon_prev_ff;
   logic          event_latched_ff;
   logic          nxt_event_latched;
   logic [EW-1:0] irq_status_ff;
   logic [EW-1:0] irq_enable_ff;
   logic [EW-1:0] nxt_irq_status;
   logic [EW-1:0] events;
   logic [31:0]   rd_mux;

   function automatic logic is_sys_on(input psf_pkg::psf_state_t s);
      return (s == psf_pkg::ST_RUN) || (s == psf_pkg::ST_STANDBY);
   endfunction : is_sys_on

   function automatic logic entering(input psf_pkg::psf_state_t cur,
                                     input psf_pkg::psf_state_t nxt,
                                     input psf_pkg::psf_state_t tgt);
      return (cur != tgt) && (nxt == tgt);
   endfunction : entering

   // Register decode.
   wire sel_cfg   = (i_addr == psf_pkg::CFG_OFFSET);
   wire sel_state = (i_addr == psf_pkg::STATE_OFFSET);
   wire sel_stat  = (i_addr == psf_pkg::IRQ_STATUS_OFFSET);
   wire sel_clr   = (i_addr == psf_pkg::IRQ_CLEAR_OFFSET);
   wire sel_en    = (i_addr == psf_pkg::IRQ_ENABLE_OFFSET);
   wire wr_cfg    = i_wr_strobe && sel_cfg;
   wire wr_en     = i_wr_strobe && sel_en;
   wire [EW-1:0] clr_bits =
      (i_wr_strobe && sel_clr) ? i_wr_data[EW-1:0] : '0;

   // Power-on event qualification.
   wire sleep_match = (i_sleep_request == invert_ff);
   wire pon_fall    = pon_prev_ff && !i_power_on_request;
   wire pon_event   = edge_sel_ff ? pon_fall
                                  : i_power_on_request;
   wire vin_ok      = i_vin_above_uv &&
                      (i_vin_below_ovlo || i_ovlo_disable);
   wire pu_ok       = vin_ok && i_below_thermal_sd &&
                      !i_trim_load_fault && !i_fuse_load_fault;
   wire pu_event    = pon_event && pu_ok;
   wire passive_go  = lpoff_en_ff && !i_board_test_enable;
   wire active_go   = !lpoff_en_ff && !i_board_test_enable && pu_event;
   wire limit_hit   = (wd_count_ff >= limit_ff);
   wire delay_done  = (wd_delay_ff == WD_LAST);

   // Next-state logic.
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         psf_pkg::ST_LOW_POWER_OFF_STATE: begin
            if (i_board_test_enable || passive_go || active_go) begin
               nxt_state = psf_pkg::ST_QUICK_POWERUP_OFF_STATE;
            end
         end
         psf_pkg::ST_QUICK_POWERUP_OFF_STATE: begin
            if (!i_self_check_fault && (event_latched_ff || pu_event)) begin
               nxt_state = psf_pkg::ST_PWRUP;
            end
         end
         psf_pkg::ST_PWRUP: begin
            if (i_seq_done) begin
               nxt_state = psf_pkg::ST_RUN;
            end
         end
         psf_pkg::ST_RUN: begin
            if (i_hard_wd_reset) begin
               nxt_state = psf_pkg::ST_WD_RST;
            end else if (!sleep_match) begin
               nxt_state = psf_pkg::ST_STANDBY;
            end
         end
         psf_pkg::ST_STANDBY: begin
            if (i_hard_wd_reset) begin
               nxt_state = psf_pkg::ST_WD_RST;
            end else if (sleep_match) begin
               nxt_state = psf_pkg::ST_RUN;
            end
         end
         psf_pkg::ST_WD_RST: begin
            if (limit_hit) begin
               nxt_state = psf_pkg::ST_FAULT;
            end else if (delay_done) begin
               nxt_state = psf_pkg::ST_RUN;
            end
         end
         psf_pkg::ST_FAULT: begin
            if (i_seq_done) begin
               nxt_state = psf_pkg::ST_LOW_POWER_OFF_STATE;
            end
         end
         default: nxt_state = psf_pkg::ST_LOW_POWER_OFF_STATE;
      endcase
   end

   // A power-up event that takes low power off to quick power-up off is remembered.
   assign nxt_event_latched =
      (state_ff == psf_pkg::ST_LOW_POWER_OFF_STATE) ? active_go :
      (state_ff == psf_pkg::ST_QUICK_POWERUP_OFF_STATE) ? event_latched_ff : 1'b0;

   // Count entries into watchdog reset; cleared when fully off.
   assign nxt_wd_count =
      entering(state_ff, nxt_state, psf_pkg::ST_WD_RST) ?
         LW'(wd_count_ff + 1'b1) :
      (state_ff == psf_pkg::ST_LOW_POWER_OFF_STATE) ? '0 : wd_count_ff;

   assign nxt_wd_delay =
      (state_ff == psf_pkg::ST_WD_RST && !delay_done) ?
         CW'(wd_delay_ff + 1'b1) : '0;

   assign events[psf_pkg::EV_RUN] =
      entering(state_ff, nxt_state, psf_pkg::ST_RUN);
   assign events[psf_pkg::EV_STANDBY] =
      entering(state_ff, nxt_state, psf_pkg::ST_STANDBY);
   assign events[psf_pkg::EV_WDRST] =
      entering(state_ff, nxt_state, psf_pkg::ST_WD_RST);
   assign events[psf_pkg::EV_FAULT] =
      entering(state_ff, nxt_state, psf_pkg::ST_FAULT);
   assign events[psf_pkg::EV_PWRUP] =
      entering(state_ff, nxt_state, psf_pkg::ST_PWRUP);

   // A new event wins over a clear in the same cycle.
   assign nxt_irq_status = (irq_status_ff & ~clr_bits) | events;

   assign rd_mux =
      sel_cfg   ? {24'h000000, limit_ff, 1'b0, edge_sel_ff,
                   lpoff_en_ff, invert_ff} :
      sel_state ? {24'h000000, wd_count_ff, 1'b0, state_ff} :
      sel_stat  ? {27'h0000000, irq_status_ff} :
      sel_en    ? {27'h0000000, irq_enable_ff} : 32'h00000000;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_ff         <= psf_pkg::ST_LOW_POWER_OFF_STATE;
         wd_count_ff      <= '0;
         wd_delay_ff      <= '0;
         pon_prev_ff      <= 1'b0;
         event_latched_ff <= 1'b0;
      end else begin
         state_ff         <= nxt_state;
         wd_count_ff      <= nxt_wd_count;
         wd_delay_ff      <= nxt_wd_delay;
         pon_prev_ff      <= i_power_on_request;
         event_latched_ff <= nxt_event_latched;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         invert_ff   <= psf_pkg::CFG_INVERT_RST;
         lpoff_en_ff <= psf_pkg::CFG_LPOFF_RST;
         edge_sel_ff <= psf_pkg::CFG_EDGE_RST;
         limit_ff    <= psf_pkg::CFG_LIMIT_RST;
      end else if (wr_cfg) begin
         invert_ff   <= i_wr_data[psf_pkg::CFG_INVERT_BIT];
         lpoff_en_ff <= i_wr_data[psf_pkg::CFG_LPOFF_BIT];
         edge_sel_ff <= i_wr_data[psf_pkg::CFG_EDGE_BIT];
         limit_ff    <= i_wr_data[psf_pkg::CFG_LIMIT_LSB +: LW];
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_status_ff     <= '0;
         irq_enable_ff     <= psf_pkg::IRQ_ENABLE_RST;
         o_irq             <= 1'b0;
         o_rd_data         <= 32'h00000000;
         o_power_state     <= 3'h0;
         o_fault_powerdown <= 1'b0;
      end else begin
         irq_status_ff     <= nxt_irq_status;
         irq_enable_ff     <= wr_en ? i_wr_data[EW-1:0] : irq_enable_ff;
         o_irq             <= |(nxt_irq_status &
                                (wr_en ? i_wr_data[EW-1:0] : irq_enable_ff));
         o_rd_data         <= i_rd_strobe ? rd_mux : 32'h00000000;
         o_power_state     <= nxt_state;
         o_fault_powerdown <= (nxt_state == psf_pkg::ST_FAULT);
      end
   end

   // Checks.
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);

   sequence s_wd_enter;
      is_sys_on(state_ff) && i_hard_wd_reset ##1
         (state_ff == psf_pkg::ST_WD_RST);
   endsequence

   sequence s_lpoff_ready;
      (state_ff == psf_pkg::ST_LOW_POWER_OFF_STATE) && !lpoff_en_ff &&
         !i_board_test_enable;
   endsequence

   property p_standby_to_run;
      (state_ff == psf_pkg::ST_STANDBY) && !i_hard_wd_reset &&
         (i_sleep_request == invert_ff) |=> (state_ff == psf_pkg::ST_RUN);
   endproperty
   a_standby_to_run: assert property (p_standby_to_run)
      else $error("standby did not move to run");

   property p_run_to_standby;
      (state_ff == psf_pkg::ST_RUN) && !i_hard_wd_reset &&
         (i_sleep_request != invert_ff) |=>
         (state_ff == psf_pkg::ST_STANDBY);
   endproperty
   a_run_to_standby: assert property (p_run_to_standby)
      else $error("run did not move to standby");

   property p_wd_entry;
      is_sys_on(state_ff) && i_hard_wd_reset |=>
         (state_ff == psf_pkg::ST_WD_RST) && o_power_state == 3'h7;
   endproperty
   a_wd_entry: assert property (p_wd_entry)
      else $error("watchdog reset not entered");

   property p_wd_return;
      (state_ff == psf_pkg::ST_WD_RST) && (wd_count_ff < limit_ff) |->
         (delay_done ##1 state_ff == psf_pkg::ST_RUN) or
         (!delay_done ##1 state_ff == psf_pkg::ST_WD_RST);
   endproperty
   a_wd_return: assert property (p_wd_return)
      else $error("watchdog reset dwell wrong");

   property p_wd_fault;
      (state_ff == psf_pkg::ST_WD_RST) && (wd_count_ff == limit_ff) |=>
         (state_ff == psf_pkg::ST_FAULT) ##1 o_fault_powerdown;
   endproperty
   a_wd_fault: assert property (p_wd_fault)
      else $error("limit reached without fault power-down");

   property p_passive_pass;
      (state_ff == psf_pkg::ST_LOW_POWER_OFF_STATE) && lpoff_en_ff &&
         !i_board_test_enable |=> (state_ff == psf_pkg::ST_QUICK_POWERUP_OFF_STATE);
   endproperty
   a_passive_pass: assert property (p_passive_pass)
      else $error("low power off did not pass through");

   property p_level_event;
      s_lpoff_ready and (!edge_sel_ff && i_power_on_request && pu_ok) |=>
         (state_ff == psf_pkg::ST_QUICK_POWERUP_OFF_STATE);
   endproperty
   a_level_event: assert property (p_level_event)
      else $error("level power-on event ignored");

   property p_edge_event;
      s_lpoff_ready and (edge_sel_ff && !i_power_on_request &&
         $past(i_power_on_request) && pu_ok) |=>
         (state_ff == psf_pkg::ST_QUICK_POWERUP_OFF_STATE);
   endproperty
   a_edge_event: assert property (p_edge_event)
      else $error("edge power-on event ignored");

   property p_unqualified_hold;
      s_lpoff_ready and !pu_ok |=> (state_ff == psf_pkg::ST_LOW_POWER_OFF_STATE);
   endproperty
   a_unqualified_hold: assert property (p_unqualified_hold)
      else $error("power-up taken without qualification");

   property p_board_test;
      (state_ff == psf_pkg::ST_LOW_POWER_OFF_STATE) && i_board_test_enable |=>
         (state_ff == psf_pkg::ST_QUICK_POWERUP_OFF_STATE);
   endproperty
   a_board_test: assert property (p_board_test)
      else $error("board test did not pass low power off");

   property p_qpu_advance;
      (state_ff == psf_pkg::ST_QUICK_POWERUP_OFF_STATE) && !i_self_check_fault &&
         (event_latched_ff || pu_event) |=>
         (state_ff == psf_pkg::ST_PWRUP);
   endproperty
   a_qpu_advance: assert property (p_qpu_advance)
      else $error("quick power-up off did not advance");

   property p_wd_count;
      s_wd_enter |-> (wd_count_ff == LW'($past(wd_count_ff) + 1'b1));
   endproperty
   a_wd_count: assert property (p_wd_count)
      else $error("watchdog count not incremented");

endmodule : psf_power_state_fsm

// ---- testbench/psf_seq_model.sv ----
`timescale 1ns/10ps

// Stands in for the external regulator sequencer: it answers a power-up
// or a fault power-down with a one-cycle done pulse after DONE_DLY cycles.
module psf_seq_model #(
   parameter int DONE_DLY = 20
) (
   // Clock and reset.
   input  wire logic       i_sys_clk,
   input  wire logic       i_arst_n,
   // State seen from the controller.
   input  wire logic [2:0] i_power_state,
   // Sequence completion.
   output logic            o_seq_done
);
   int  wait_ff;
   wire busy = (i_power_state == psf_pkg::ST_PWRUP) ||
               (i_power_state == psf_pkg::ST_FAULT);

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wait_ff    <= 0;
         o_seq_done <= 1'b0;
      end else begin
         o_seq_done <= busy && (wait_ff == DONE_DLY) && !o_seq_done;
         wait_ff    <= (busy && !o_seq_done) ? wait_ff + 1 : 0;
      end
   end
endmodule : psf_seq_model

// ---- testbench/psf_power_state_fsm_tb.sv ----
`timescale 1ns/10ps

module psf_power_state_fsm_tb;
   logic        i_sys_clk, i_arst_n, i_wr_strobe, i_rd_strobe;
   logic [7:0]  i_addr;
   logic [31:0] i_wr_data, o_rd_data, v;
   logic        i_sleep_request, i_power_on_request, i_board_test_enable;
   logic        i_hard_wd_reset, i_vin_above_uv, i_vin_below_ovlo;
   logic        i_ovlo_disable, i_below_thermal_sd, i_trim_load_fault;
   logic        i_fuse_load_fault, i_self_check_fault, i_seq_done;
   logic [2:0]  o_power_state;
   logic        o_fault_powerdown, o_irq;
   int          mismatches, samples_checked;

   psf_power_state_fsm dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe),
      .i_rd_strobe(i_rd_strobe), .o_rd_data(o_rd_data),
      .i_sleep_request(i_sleep_request),
      .i_power_on_request(i_power_on_request),
      .i_board_test_enable(i_board_test_enable),
      .i_hard_wd_reset(i_hard_wd_reset), .i_vin_above_uv(i_vin_above_uv),
      .i_vin_below_ovlo(i_vin_below_ovlo), .i_ovlo_disable(i_ovlo_disable),
      .i_below_thermal_sd(i_below_thermal_sd),
      .i_trim_load_fault(i_trim_load_fault),
      .i_fuse_load_fault(i_fuse_load_fault),
      .i_self_check_fault(i_self_check_fault), .i_seq_done(i_seq_done),
      .o_power_state(o_power_state), .o_fault_powerdown(o_fault_powerdown),
      .o_irq(o_irq));

   psf_seq_model #(.DONE_DLY(20)) seq (.i_sys_clk(i_sys_clk),
      .i_arst_n(i_arst_n), .i_power_state(o_power_state),
      .o_seq_done(i_seq_done));

   initial begin
      i_sys_clk = 1'b0;
      forever #5 i_sys_clk = ~i_sys_clk;
   end

   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Waits up to lim cycles for the state, then compares it.
   task automatic wait_state(input logic [2:0] exp, input int lim);
      int n = 0;
      while (o_power_state !== exp && n < lim) begin
         @(posedge i_sys_clk);
         #1;
         n++;
      end
      check(32'(o_power_state), 32'(exp));
   endtask : wait_state

   task automatic idle(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask : idle

   // Each set bit spoils one qualifier: supply low, supply high,
   // over temperature, trim fault, configuration load fault.
   task automatic set_sup(input logic [4:0] bad);
      i_vin_above_uv     <= ~bad[0];
      i_vin_below_ovlo   <= ~bad[1];
      i_below_thermal_sd <= ~bad[2];
      i_trim_load_fault  <= bad[3];
      i_fuse_load_fault  <= bad[4];
   endtask : set_sup

   task automatic do_reset();
      i_arst_n            <= 1'b0;
      {i_wr_strobe, i_rd_strobe, i_hard_wd_reset} <= 3'h0;
      {i_sleep_request, i_power_on_request, i_board_test_enable} <= 3'h0;
      {i_ovlo_disable, i_self_check_fault} <= 2'h0;
      i_addr              <= 8'h00;
      i_wr_data           <= 32'h0;
      set_sup(5'h00);
      idle(5);
      i_arst_n            <= 1'b1;
      idle(1);
   endtask : do_reset

   task automatic regwr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_sys_clk);
      i_wr_strobe <= 1'b1;
      i_addr      <= a;
      i_wr_data   <= d;
      @(posedge i_sys_clk);
      i_wr_strobe <= 1'b0;
      #1;
   endtask : regwr

   task automatic regrd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_sys_clk);
      i_rd_strobe <= 1'b1;
      i_addr      <= a;
      @(posedge i_sys_clk);
      i_rd_strobe <= 1'b0;
      #1;
      d = o_rd_data;
   endtask : regrd

   task automatic t_regs();
      regrd(psf_pkg::CFG_OFFSET, v);
      check(v, 32'h30);
      regrd(8'h14, v);
      check(v, 32'h0);
      regwr(psf_pkg::IRQ_ENABLE_OFFSET, 32'h1f);
      regrd(psf_pkg::IRQ_ENABLE_OFFSET, v);
      check(v, 32'h1f);
      regrd(psf_pkg::IRQ_CLEAR_OFFSET, v);
      check(v, 32'h0);
      regwr(psf_pkg::IRQ_ENABLE_OFFSET, 32'h00);
   endtask : t_regs

   task automatic t_level_power_up();
      i_power_on_request <= 1'b1;
      for (int k = 0; k < 5; k++) begin
         set_sup(5'h01 << k);
         idle(4);
         wait_state(psf_pkg::ST_LOW_POWER_OFF_STATE, 0);
      end
      set_sup(5'h02);
      i_ovlo_disable <= 1'b1;
      wait_state(psf_pkg::ST_QUICK_POWERUP_OFF_STATE, 4);
      wait_state(psf_pkg::ST_PWRUP, 4);
      wait_state(psf_pkg::ST_RUN, 40);
   endtask : t_level_power_up

   task automatic t_sleep();
      i_sleep_request <= 1'b1;
      wait_state(psf_pkg::ST_STANDBY, 4);
      i_sleep_request <= 1'b0;
      wait_state(psf_pkg::ST_RUN, 4);
      regwr(psf_pkg::CFG_OFFSET, 32'h31);
      wait_state(psf_pkg::ST_STANDBY, 4);
      i_sleep_request <= 1'b1;
      wait_state(psf_pkg::ST_RUN, 4);
      regwr(psf_pkg::CFG_OFFSET, 32'h30);
      wait_state(psf_pkg::ST_STANDBY, 4);
      i_sleep_request <= 1'b0;
      wait_state(psf_pkg::ST_RUN, 4);
   endtask : t_sleep

   // Limit 3: two watchdog resets return to run, the third ends in fault.
   task automatic t_watchdog();
      // Drop the request so the return to low power off stays put.
      i_power_on_request <= 1'b0;
      regwr(psf_pkg::IRQ_ENABLE_OFFSET, 32'h04);
      for (int k = 1; k <= 3; k++) begin
         @(posedge i_sys_clk);
         i_hard_wd_reset <= 1'b1;
         @(posedge i_sys_clk);
         i_hard_wd_reset <= 1'b0;
         #1;
         wait_state(psf_pkg::ST_WD_RST, 0);
         regrd(psf_pkg::STATE_OFFSET, v);
         check(v, {24'h0, 4'(k), (k < 3) ? 4'h7 : 4'h5});
         check(32'(o_irq), 32'h1);
         regwr(psf_pkg::IRQ_CLEAR_OFFSET, 32'h1f);
         check(32'(o_irq), 32'h0);
         if (k < 3) begin
            idle(2995);
            wait_state(psf_pkg::ST_WD_RST, 0);
            wait_state(psf_pkg::ST_RUN, 1);
            check(32'(o_irq), 32'h0);
         end
      end
      wait_state(psf_pkg::ST_FAULT, 0);
      check(32'(o_fault_powerdown), 32'h1);
      wait_state(psf_pkg::ST_LOW_POWER_OFF_STATE, 40);
   endtask : t_watchdog

   task automatic t_edge();
      regwr(psf_pkg::CFG_OFFSET, 32'h34);
      i_power_on_request <= 1'b1;
      idle(4);
      wait_state(psf_pkg::ST_LOW_POWER_OFF_STATE, 0);
      i_power_on_request <= 1'b0;
      wait_state(psf_pkg::ST_QUICK_POWERUP_OFF_STATE, 4);
   endtask : t_edge

   task automatic t_lpoff();
      regwr(psf_pkg::CFG_OFFSET, 32'h32);
      wait_state(psf_pkg::ST_QUICK_POWERUP_OFF_STATE, 4);
      i_self_check_fault <= 1'b1;
      i_power_on_request <= 1'b1;
      idle(4);
      wait_state(psf_pkg::ST_QUICK_POWERUP_OFF_STATE, 0);
      i_self_check_fault <= 1'b0;
      wait_state(psf_pkg::ST_PWRUP, 4);
   endtask : t_lpoff

   task automatic t_board_test();
      i_board_test_enable <= 1'b1;
      wait_state(psf_pkg::ST_QUICK_POWERUP_OFF_STATE, 4);
   endtask : t_board_test

   initial begin
      mismatches      = 0;
      samples_checked = 0;
      do_reset();
      t_regs();
      t_level_power_up();
      t_sleep();
      t_watchdog();
      t_edge();
      do_reset();
      t_lpoff();
      do_reset();
      t_board_test();
      conclude();
   end

   // The whole sequence needs about 6100 cycles.
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      mismatches++;
      conclude();
   end
endmodule : psf_power_state_fsm_tb
